/* tdp_pkg.sv */
// Shared constants, register map and decode helpers of the two-wire debug port.
`default_nettype none
package tdp_pkg;
    // ========================================================================
    // Command byte layout
    localparam int CMD_OP_HI   = 7;
    localparam int CMD_OP_LO   = 3;
    localparam int CMD_RSP_BIT = 2;
    localparam int CMD_NARG_HI = 1;
    localparam int CMD_NARG_LO = 0;

    // Instruction codes, the five upper bits of the command byte.
    localparam logic [4:0] OP_ERASE  = 5'h02;
    localparam logic [4:0] OP_WRCFG  = 5'h03;
    localparam logic [4:0] OP_RDCFG  = 5'h04;
    localparam logic [4:0] OP_STATUS = 5'h06;
    localparam logic [4:0] OP_HALT   = 5'h08;
    localparam logic [4:0] OP_RESUME = 5'h09;
    localparam logic [4:0] OP_DINSTR = 5'h0a;
    localparam logic [4:0] OP_STEP   = 5'h0b;
    localparam logic [4:0] OP_STEPRP = 5'h0c;
    localparam logic [4:0] OP_CHIPID = 5'h0d;

    // Status byte bit positions and the configuration reset value.
    localparam int         STAT_ERASE_BUSY = 7;
    localparam int         STAT_HALTED     = 5;
    localparam int         STAT_LOCK       = 2;
    localparam logic [7:0] CFG_RESET       = 8'h00;

    // ========================================================================
    // Link timing
    localparam logic [1:0] ENTRY_LAST   = 2'h1;  // Counter value at the second entry edge.
    localparam int         HCLK_NS      = 100;
    localparam int         DCLK_HALF_NS = 400;
    localparam logic [2:0] DCLK_HALF    = 3'((DCLK_HALF_NS + HCLK_NS - 1) / HCLK_NS);

    // ========================================================================
    // Host controller register map and fields
    localparam logic [7:0] REG_CMD   = 8'h00;
    localparam logic [7:0] REG_CTRL  = 8'h04;
    localparam logic [7:0] REG_STAT  = 8'h08;
    localparam logic [7:0] REG_RXD   = 8'h0c;
    localparam int         CTRL_ENTER = 0;
    localparam int         HST_BUSY   = 0;
    localparam int         HST_INDBG  = 1;

    // Number of response bytes a command byte asks for.
    function automatic logic [1:0] rsp_bytes(input logic [7:0] c);
        logic [1:0] n;
        n = {1'b0, c[CMD_RSP_BIT]};
        if (c[CMD_OP_HI:CMD_OP_LO] == OP_CHIPID)
        begin
            n = 2'h2;
        end
        return n;
    endfunction
endpackage
`default_nettype wire

/* tdp_if.sv */
// Link wires between the debug host and the debug port, with line resolution.
`timescale 1ns/1ps
`default_nettype none
interface tdp_if;
    logic dclk;        // Debug clock line, made by the host.
    logic chip_rst_n;  // Chip reset line, active low.
    logic dd_host_o;
    logic dd_host_oe;
    logic dd_dev_o;
    logic dd_dev_oe;
    logic dd;          // Resolved debug data line.

    // The line is pulled high when nobody drives it.
    assign dd = dd_dev_oe ? dd_dev_o : (dd_host_oe ? dd_host_o : 1'b1);

    modport host (output dclk, output chip_rst_n, output dd_host_o, output dd_host_oe,
                  input dd);
    modport dev  (input dclk, input chip_rst_n, input dd, output dd_dev_o,
                  output dd_dev_oe);
endinterface
`default_nettype wire

/* tdp_dev.sv */
// Device end of the two-wire debug port, clocked by the debug clock line.
//
// Overview of operation
// - Two clock rises under held reset enter debug.
// - Pins are debug only in debug mode.
// - Drive on rising edge, sample on falling.
// - Commands are one to four bytes, optional reply.
// - Command bits seven to three select operation.
// - Command bit two asks for reply byte.
// - Command bits one, zero count argument bytes.
// - Lock allows only erase, status, identity.
// - Status byte carries the lock flag.
// - Reported lock updates on halt/resume/step attempts.
// - Mass erase clears the lock flag.
// - One configuration byte, written and read back.
// - Erase disabled after any command other than status or erase.
// - Status command returns the status byte.
// - Config write and config read codes.
// - Halt stops CPU; resume only while halted.
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tdp_dev #(
    parameter logic [15:0] CHIP_ID = 16'h1234  // Arbitrary identity value.
) (
    // Link side.
    tdp_if.dev                lnk,
    // Power-on reset of the port, asynchronous, active low.
    input  wire logic         hresetn,
    // System side: lock request and flash state.
    input  wire logic         lock_set_i,
    input  wire logic         erase_busy_i,
    // System side: debug state.
    output logic              dbg_mode_o,
    output logic              cpu_halt_o,
    output logic [7:0]        cfg_o,
    output logic              lock_o,
    output logic              erase_tgl_o,
    output logic              exec_tgl_o,
    output logic [4:0]        exec_op_o,
    output logic [23:0]       instr_o
);
    // ========================================================================
    // State types
    typedef enum logic [1:0] {PH_CMD, PH_ARG, PH_RSP} tdp_ph_t;

    // Falling-edge state: everything that samples the data line.
    typedef struct packed {
        tdp_ph_t     ph;
        logic [2:0]  bitc;
        logic [1:0]  argc;
        logic        rspc;
        logic [7:0]  sh;
        logic [7:0]  cmd;
        logic [23:0] args;
        logic [15:0] rsp;
        logic [7:0]  cfg;
        logic        lock;
        logic        rpt_lock;
        logic        halted;
        logic        erase_ok;
        logic        erase_tgl;
        logic        exec_tgl;
        logic [4:0]  exec_op;
        logic [23:0] instr;
        logic        lk_s1;
        logic        lk_s2;
        logic        lk_s3;
        logic        eb_s1;
        logic        eb_s2;
    } tdp_dst_t;

    // Rising-edge state: mode flag and data line driver.
    typedef struct packed {
        logic dbg;
        logic oe;
        logic o;
    } tdp_drv_t;

    tdp_dst_t   n_r;
    tdp_dst_t   n_nxt;
    tdp_drv_t   p_r;
    tdp_drv_t   p_nxt;
    logic [1:0] ent_cnt_r;

    // ========================================================================
    // Debug mode entry
    // Counts clock rises while the chip reset line is low. The reset line
    // itself clears the counter, so no synchroniser is needed on it and
    // the two short entry edges are never lost to synchroniser latency.
    always_ff @(posedge lnk.dclk or posedge lnk.chip_rst_n)
    begin
        if (lnk.chip_rst_n)
        begin
            ent_cnt_r <= 2'h0;
        end
        else if (ent_cnt_r != 2'h3)
        begin
            ent_cnt_r <= ent_cnt_r + 2'h1;
        end
    end

    // ========================================================================
    // Command receiver and executor
    // Runs on the falling edge, where the data line is sampled. The debug
    // clock stops between frames, so the system inputs below only advance
    // while the host is clocking; their effect is seen on the next command.
    always_comb
    begin
        logic [7:0]  byte_in;
        logic [7:0]  c;
        logic [23:0] a;
        logic [4:0]  op;
        logic [1:0]  nrsp;
        logic [7:0]  stat;
        logic        run;
        logic        clr_lock;
        byte_in  = {n_r.sh[6:0], lnk.dd};
        c        = n_r.cmd;
        a        = {n_r.args[15:0], byte_in};
        op       = 5'h00;
        nrsp     = 2'h0;
        stat     = 8'h00;
        run      = 1'b0;
        clr_lock = 1'b0;
        n_nxt    = n_r;

        // Two-flop synchronisers for the system-side levels.
        n_nxt.lk_s1 = lock_set_i;
        n_nxt.lk_s2 = n_r.lk_s1;
        n_nxt.lk_s3 = n_r.lk_s2;
        n_nxt.eb_s1 = erase_busy_i;
        n_nxt.eb_s2 = n_r.eb_s1;

        // Bits only count in debug mode with the chip reset released.
        if (p_r.dbg && ent_cnt_r == 2'h0)
        begin
            unique case (n_r.ph)
                PH_CMD, PH_ARG:
                begin
                    n_nxt.sh   = byte_in;
                    n_nxt.bitc = n_r.bitc + 3'h1;
                    if (n_r.bitc == 3'h7)
                    begin
                        if (n_r.ph == PH_CMD)
                        begin
                            c         = byte_in;
                            a         = n_r.args;
                            n_nxt.cmd = byte_in;
                            n_nxt.argc = byte_in[tdp_pkg::CMD_NARG_HI:
                                                 tdp_pkg::CMD_NARG_LO];
                            run       = (n_nxt.argc == 2'h0);
                            n_nxt.ph  = run ? PH_CMD : PH_ARG;
                        end
                        else
                        begin
                            n_nxt.args = a;
                            n_nxt.argc = n_r.argc - 2'h1;
                            run        = (n_r.argc == 2'h1);
                        end
                    end
                end
                PH_RSP:
                begin
                    n_nxt.rsp  = {n_r.rsp[14:0], 1'b0};
                    n_nxt.bitc = n_r.bitc + 3'h1;
                    if (n_r.bitc == 3'h7)
                    begin
                        n_nxt.rspc = 1'b0;
                        n_nxt.ph   = n_r.rspc ? PH_RSP : PH_CMD;
                    end
                end
                default:
                begin
                    n_nxt.ph = PH_CMD;
                end
            endcase
        end

        // Execute once the last argument byte is in.
        if (run)
        begin
            op   = c[tdp_pkg::CMD_OP_HI:tdp_pkg::CMD_OP_LO];
            nrsp = tdp_pkg::rsp_bytes(c);
            stat[tdp_pkg::STAT_ERASE_BUSY] = n_r.eb_s2;
            stat[tdp_pkg::STAT_HALTED]     = n_r.halted;
            stat[tdp_pkg::STAT_LOCK]       = n_r.rpt_lock;
            n_nxt.rsp = 16'h0000;
            if (op != tdp_pkg::OP_STATUS && op != tdp_pkg::OP_ERASE)
            begin
                n_nxt.erase_ok = 1'b0;
            end
            if (op == tdp_pkg::OP_HALT || op == tdp_pkg::OP_RESUME ||
                op == tdp_pkg::OP_DINSTR || op == tdp_pkg::OP_STEP ||
                op == tdp_pkg::OP_STEPRP)
            begin
                n_nxt.rpt_lock = n_r.lock;
            end
            // A locked port still answers with the asked byte count, as zeros.
            if (!n_r.lock || op == tdp_pkg::OP_ERASE || op == tdp_pkg::OP_STATUS ||
                op == tdp_pkg::OP_CHIPID)
            begin
                case (op)
                    tdp_pkg::OP_ERASE:
                    begin
                        if (n_r.erase_ok)
                        begin
                            clr_lock        = 1'b1;
                            n_nxt.rpt_lock  = 1'b0;
                            n_nxt.erase_tgl = ~n_r.erase_tgl;
                        end
                    end
                    tdp_pkg::OP_WRCFG:  n_nxt.cfg = a[7:0];
                    tdp_pkg::OP_RDCFG:  n_nxt.rsp = {n_r.cfg, 8'h00};
                    tdp_pkg::OP_STATUS: n_nxt.rsp = {stat, 8'h00};
                    tdp_pkg::OP_HALT:   n_nxt.halted = 1'b1;
                    tdp_pkg::OP_RESUME:
                    begin
                        if (n_r.halted)
                        begin
                            n_nxt.halted = 1'b0;
                        end
                    end
                    tdp_pkg::OP_DINSTR, tdp_pkg::OP_STEP, tdp_pkg::OP_STEPRP:
                    begin
                        if (n_r.halted)
                        begin
                            n_nxt.exec_tgl = ~n_r.exec_tgl;
                            n_nxt.exec_op  = op;
                            n_nxt.instr    = a;
                        end
                    end
                    tdp_pkg::OP_CHIPID: n_nxt.rsp = CHIP_ID;
                    default: ;
                endcase
            end
            n_nxt.rspc = (nrsp == 2'h2);
            n_nxt.ph   = (nrsp != 2'h0) ? PH_RSP : PH_CMD;
        end

        // A lock request arriving with an erase still sets the flag.
        n_nxt.lock = (n_r.lock & ~clr_lock) | (n_r.lk_s2 & ~n_r.lk_s3);
    end

    always_ff @(negedge lnk.dclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            n_r          <= '0;
            n_r.ph       <= PH_CMD;
            n_r.cfg      <= tdp_pkg::CFG_RESET;
            n_r.erase_ok <= 1'b1;
        end
        else
        begin
            n_r <= n_nxt;
        end
    end

    // ========================================================================
    // Mode flag and data line driver
    // Reply bits are launched on the rising edge, one half period ahead of
    // the host's sampling edge.
    always_comb
    begin
        p_nxt     = p_r;
        p_nxt.dbg = p_r.dbg | (ent_cnt_r == tdp_pkg::ENTRY_LAST);
        p_nxt.oe  = p_r.dbg && n_r.ph == PH_RSP;
        p_nxt.o   = n_r.rsp[15];
    end

    always_ff @(posedge lnk.dclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            p_r <= '0;
        end
        else
        begin
            p_r <= p_nxt;
        end
    end

    // ========================================================================
    // Outputs
    // The clock stops after the last reply bit, so the enable is also cut
    // by the falling-edge phase; otherwise it would hang on into the next
    // command and fight the host.
    assign lnk.dd_dev_oe = p_r.oe & (n_r.ph == PH_RSP);
    assign lnk.dd_dev_o  = p_r.o;
    assign dbg_mode_o    = p_r.dbg;
    assign cpu_halt_o    = n_r.halted;
    assign cfg_o         = n_r.cfg;
    assign lock_o        = n_r.lock;
    assign erase_tgl_o   = n_r.erase_tgl;
    assign exec_tgl_o    = n_r.exec_tgl;
    assign exec_op_o     = n_r.exec_op;
    assign instr_o       = n_r.instr;
endmodule
`default_nettype wire

/* tdp_host.sv */
// Host end of the two-wire debug port: AHB-Lite registers and link sequencer.
`timescale 1ns/1ps
`default_nettype none
module tdp_host (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Link side.
    tdp_if.host              lnk
);
    // ========================================================================
    // State
    typedef enum logic [1:0] {HS_IDLE, HS_ENTER, HS_XFER} tdp_hs_t;

    typedef struct packed {
        logic        rdy;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] rdata;
        tdp_hs_t     st;
        logic [2:0]  div;
        logic        dclk;
        logic        rst_pin;
        logic        oe;
        logic        o;
        logic [31:0] sh;
        logic [5:0]  nout;
        logic [4:0]  nin;
        logic [15:0] rx;
        logic        dbg;
        logic        dd_s1;
        logic        dd_s2;
    } tdp_hst_t;

    tdp_hst_t h_r;
    tdp_hst_t h_nxt;

    // ========================================================================
    // Bus slave and sequencer
    // The slave never waits: read data is prepared in the address phase.
    // Writes while a sequence runs are dropped rather than stalled.
    always_comb
    begin
        logic        rise;
        logic        fall;
        logic [31:0] rd;
        rise  = 1'b0;
        fall  = 1'b0;
        rd    = 32'h0000_0000;
        h_nxt = h_r;
        h_nxt.rdy   = 1'b1;
        h_nxt.wr    = 1'b0;
        h_nxt.dd_s1 = lnk.dd;
        h_nxt.dd_s2 = h_r.dd_s1;

        // Address phase.
        if (hsel && htrans[1] && hready)
        begin
            h_nxt.wr   = hwrite;
            h_nxt.addr = haddr[7:0];
            unique case (haddr[7:0])
                tdp_pkg::REG_STAT: rd = {30'h0, h_r.dbg, h_r.st != HS_IDLE};
                tdp_pkg::REG_RXD:  rd = {16'h0000, h_r.rx};
                default:           rd = 32'h0000_0000;
            endcase
            h_nxt.rdata = rd;
        end

        // Divided debug clock runs only during a sequence.
        if (h_r.st != HS_IDLE)
        begin
            h_nxt.div = h_r.div + 3'h1;
            if (h_r.div == tdp_pkg::DCLK_HALF - 3'h1)
            begin
                h_nxt.div  = 3'h0;
                h_nxt.dclk = ~h_r.dclk;
                rise       = ~h_r.dclk;
                fall       = h_r.dclk;
            end
        end

        unique case (h_r.st)
            HS_IDLE:
            begin
                // The device samples the last host bit at the closing fall, so the
                // line is let go one cycle later to keep that sample clean.
                h_nxt.oe = 1'b0;
                if (h_r.wr && h_r.addr == tdp_pkg::REG_CTRL && hwdata[tdp_pkg::CTRL_ENTER])
                begin
                    h_nxt.st      = HS_ENTER;
                    h_nxt.rst_pin = 1'b0;
                    h_nxt.nout    = 6'h00;
                end
                else if (h_r.wr && h_r.addr == tdp_pkg::REG_CMD && h_r.dbg)
                begin
                    h_nxt.st   = HS_XFER;
                    h_nxt.sh   = {hwdata[7:0], hwdata[15:8], hwdata[23:16], hwdata[31:24]};
                    h_nxt.nout = {3'(hwdata[1:0]) + 3'h1, 3'h0};
                    h_nxt.nin  = {tdp_pkg::rsp_bytes(hwdata[7:0]), 3'h0};
                    h_nxt.rx   = 16'h0000;
                end
            end
            HS_ENTER:
            begin
                if (rise)
                begin
                    h_nxt.nout = h_r.nout + 6'h01;
                end
                if (fall && h_r.nout == 6'h02)
                begin
                    h_nxt.st      = HS_IDLE;
                    h_nxt.rst_pin = 1'b1;
                    h_nxt.dbg     = 1'b1;
                end
            end
            HS_XFER:
            begin
                if (rise)
                begin
                    h_nxt.oe = (h_r.nout != 6'h00);
                    h_nxt.o  = h_r.sh[31];
                    if (h_r.nout != 6'h00)
                    begin
                        h_nxt.sh   = {h_r.sh[30:0], 1'b0};
                        h_nxt.nout = h_r.nout - 6'h01;
                    end
                end
                if (fall && !h_r.oe)
                begin
                    h_nxt.rx  = {h_r.rx[14:0], h_r.dd_s2};
                    h_nxt.nin = h_r.nin - 5'h01;
                end
                if (fall && h_r.nout == 6'h00 && (h_r.oe ? h_r.nin == 5'h00 : h_r.nin == 5'h01))
                begin
                    h_nxt.st = HS_IDLE;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            h_r         <= '0;
            h_r.st      <= HS_IDLE;
            h_r.rst_pin <= 1'b1;
        end
        else
        begin
            h_r <= h_nxt;
        end
    end

    // ========================================================================
    // Outputs
    assign hreadyout      = h_r.rdy;
    assign hresp          = 1'b0;
    assign hrdata         = h_r.rdata;
    assign lnk.dclk       = h_r.dclk;
    assign lnk.chip_rst_n = h_r.rst_pin;
    assign lnk.dd_host_o  = h_r.o;
    assign lnk.dd_host_oe = h_r.oe;
endmodule
`default_nettype wire

/* tdp_properties.sv */
// Concurrent checks on the debug link wires.
`timescale 1ns/1ps
`default_nettype none
module tdp_chk (
    // Host clock domain and link wires.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dclk,
    input wire logic chip_rst_n,
    input wire logic dd_host_oe,
    input wire logic dd_dev_oe,
    input wire logic dd
);
    // ========
    // Link edge counters
    logic       dclk_q;
    logic [4:0] rise_r;
    logic [4:0] fall_r;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // The counters clear while their window is shut, so they need no reset.
    always_ff @(posedge hclk)
    begin
        dclk_q <= dclk;
        rise_r <= chip_rst_n ? 5'h0 : rise_r + 5'(dclk & ~dclk_q);
        fall_r <= dd_dev_oe ? fall_r + 5'(dclk_q & ~dclk) : 5'h0;
    end
    // A single driver, a pulled-up idle line, entry by two rises and whole-byte replies.
    a_no_clash: assert property (!(dd_dev_oe && dd_host_oe))
        else $error("two drivers");
    a_idle_high: assert property (!dd_dev_oe && !dd_host_oe |-> dd)
        else $error("idle line low");
    a_entry_two: assert property ($rose(chip_rst_n) |-> rise_r == 5'h2)
        else $error("bad entry count");
    a_quiet_entry: assert property (!chip_rst_n |-> !dd_dev_oe)
        else $error("drive in entry");
    a_drive_rise: assert property ($rose(dd_dev_oe) |-> $rose(dclk))
        else $error("drive off rise");
    a_hold_fall: assert property ($fell(dclk) |-> $past(dd) == $past(dd, 2))
        else $error("data moved at fall");
    a_clk_half: assert property ($rose(dclk) |-> dclk [*4] ##1 !dclk)
        else $error("bad high time");
    // The closing fall shuts the enable in its own step, so the count stops one short.
    a_reply_len: assert property ($fell(dd_dev_oe) |-> fall_r == 5'h7 || fall_r == 5'hf)
        else $error("partial reply");
    c_entry: cover property ($rose(chip_rst_n));
    c_reply1: cover property ($fell(dd_dev_oe) && fall_r == 5'h7);
    c_reply2: cover property ($fell(dd_dev_oe) && fall_r == 5'hf);
endmodule
`default_nettype wire

/* test_two_wire_debug_port.sv */
// Self-checking bench joining the host and device ends of the debug port.
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_debug_port;
    // ========
    // Bench signals
    localparam logic [15:0] ID = 16'h5a3c;  // Arbitrary identity value.
    logic        hclk = 1'b0, hwrite = 1'b0, rxd_dp = 1'b0;
    logic        hresetn;
    logic        lock_set = 1'b0, busy_in = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, dbg_mode, halted, lock, er_tgl, ex_tgl, eb, t;
    logic [23:0] instr;
    logic [7:0]  cfg, v;
    logic [4:0]  op;
    logic [15:0] eq[$], mq[$];
    logic [31:0] xs[3] = '{32'ha755, 32'h5c, 32'h3b65};
    int          checks = 0, n_mismatch = 0, cyc = 0;
    tdp_if lnk ();
    tdp_host u_tdp_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .lnk(lnk));
    tdp_dev #(.CHIP_ID(ID)) u_tdp_dev (.lnk(lnk), .hresetn(hresetn), .lock_set_i(lock_set),
        .erase_busy_i(busy_in), .dbg_mode_o(dbg_mode), .cpu_halt_o(halted), .cfg_o(cfg),
        .lock_o(lock), .erase_tgl_o(er_tgl), .exec_tgl_o(ex_tgl), .exec_op_o(op),
        .instr_o(instr));
    tdp_chk u_tdp_chk (.hclk(hclk), .hresetn(hresetn), .dclk(lnk.dclk), .dd(lnk.dd),
        .chip_rst_n(lnk.chip_rst_n), .dd_host_oe(lnk.dd_host_oe), .dd_dev_oe(lnk.dd_dev_oe));
    // A 100 ns bus clock.
    always #50 hclk = ~hclk;
    // Compare and count.
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        n_mismatch += int'(seen !== exp);
        if (seen !== exp) $display("ERROR %s expected %h seen %h", nm, exp, seen);
    endtask
    task automatic give_verdict();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One AHB-Lite single transfer; an RXD data phase is flagged to the monitor.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        rxd_dp <= !w && a == tdp_pkg::REG_RXD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        rxd_dp <= 1'b0;
    endtask
    // Send a command, wait out busy, and note the reply under a mask (zero mask: no read).
    task automatic cmd(input logic [31:0] w, input logic [15:0] e, input logic [15:0] m);
        bus(1'b1, tdp_pkg::REG_CMD, w);
        do bus(1'b0, tdp_pkg::REG_STAT, 32'h0); while (rd[tdp_pkg::HST_BUSY] !== 1'b0);
        if (m != 16'h0)
        begin
            eq.push_back(e);
            mq.push_back(m);
            bus(1'b0, tdp_pkg::REG_RXD, 32'h0);
        end
    endtask
    task automatic enter();
        bus(1'b1, tdp_pkg::REG_CTRL, 32'h1);
        do bus(1'b0, tdp_pkg::REG_STAT, 32'h0); while (rd[tdp_pkg::HST_INDBG] !== 1'b1);
        chk("dbg_mode", dbg_mode, 1'b1);
    endtask
    // Monitor: match each reply with the oldest note; the cycle ceiling cuts a hang short.
    always @(posedge hclk)
    begin
        cyc++;
        if (rxd_dp && eq.size() > 0)
        begin
            chk("rxd", hrdata[15:0] & mq[0], eq[0]);
            eq.delete(0);
            mq.delete(0);
        end
        if (cyc == 60000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    // Main sequence.
    initial
    begin
        hresetn <= 1'b0;  // A real falling edge, so every asynchronous reset fires.
        void'($urandom(26620));
        eb = 1'($urandom);
        v = 8'($urandom);
        busy_in <= eb;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 8'h10, 32'h0);
        chk("unmapped", rd[15:0], 16'h0);
        bus(1'b1, tdp_pkg::REG_CMD, 32'h44);
        chk("no_mode", dbg_mode, 1'b0);
        enter();
        cmd(32'h34, {eb, 7'h0}, 16'hff);
        cmd({16'h0, v, 8'h19}, 16'h0, 16'h0);
        chk("cfg", cfg, v);
        cmd(32'h24, v, 16'hff);
        t = ex_tgl;
        cmd(32'h1155, 16'h0, 16'h0);
        chk("no_exec", ex_tgl, t);
        cmd(32'h44, 16'h0, 16'h0);
        chk("halt", halted, 1'b1);
        cmd(32'h34, {eb, 7'h20}, 16'hff);
        foreach (xs[i])
        begin
            t = ex_tgl;
            cmd(xs[i], 16'h0, 16'h0);
            chk("exec", ex_tgl, !t);
            chk("op", op, xs[i][7:3]);
        end
        chk("arg", instr[7:0], 8'h3b);
        cmd(32'h91c4b257, 16'h0, 16'h0);
        chk("arg3", instr[23:8], 16'hb2c4);
        cmd(32'h4c, 16'h0, 16'h0);
        chk("resume", halted, 1'b0);
        cmd(32'h68, ID, 16'hffff);
        $display("test commands done");
        lock_set <= 1'b1;
        cmd(32'h34, {eb, 7'h0}, 16'hff);
        chk("lock", lock, 1'b1);
        cmd(32'h44, 16'h0, 16'h0);
        chk("locked_halt", halted, 1'b0);
        cmd(32'h34, {eb, 7'h4}, 16'hff);
        cmd(32'h24, 16'h0, 16'hff);
        cmd(32'h68, ID, 16'hffff);
        $display("test lock done");
        hresetn <= 1'b0;
        lock_set <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        enter();
        lock_set <= 1'b1;
        cmd(32'h34, {eb, 7'h0}, 16'hff);
        chk("relock", lock, 1'b1);
        t = er_tgl;
        cmd(32'h10, 16'h0, 16'h0);
        chk("erase", er_tgl, !t);
        chk("unlock", lock, 1'b0);
        cmd({16'h0, ~v, 8'h19}, 16'h0, 16'h0);
        chk("cfg2", cfg, 8'(~v));
        t = er_tgl;
        cmd(32'h10, 16'h0, 16'h0);
        chk("no_erase", er_tgl, t);
        $display("test erase done");
        give_verdict();
    end
endmodule
`default_nettype wire
